// file: src/fifo_if.sv
// Interface: fill and drain sides of the symbol buffer
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(parameter int W = 32, parameter int LW = 4);
  logic          push_valid;  // Producer offers a word
  logic          push_ready;  // Buffer has room
  logic [W-1:0]  push_data;   // Word offered
  logic          pop_valid;   // Buffer holds a word
  logic          pop_ready;   // Consumer takes the word
  logic [W-1:0]  pop_data;    // Oldest word
  logic [LW-1:0] level;       // Words held

  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data, level);
  modport user  (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data, level);
endinterface
`default_nettype wire

// file: src/sym_fifo.sv
// Module: parameterised first-in first-out buffer for I/Q pairs
`timescale 1ns/1ps
`default_nettype none
module sym_fifo #(
  parameter int WIDTH = 32,  // Word width
  parameter int DEPTH = 8,   // Words held
  parameter int LW    = 4    // Level width, must hold DEPTH
) (
  input wire logic clk,    // Clock
  input wire logic reset,  // Synchronous reset, active high
  fifo_if.store    f       // Fill and drain sides
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [PW-1:0]    wp_r;         // Write pointer
  logic [PW-1:0]    rp_r;         // Read pointer
  logic [LW-1:0]    cnt_r;        // Words held
  logic [LW-1:0]    cnt_nxt;      // Next word count
  logic             ready_r;      // Registered not-full
  logic             valid_r;      // Registered not-empty
  logic             push;         // Word accepted
  logic             pop;          // Word removed

  assign push       = f.push_valid & ready_r;
  assign pop        = valid_r & f.pop_ready;
  assign f.push_ready = ready_r;
  assign f.pop_valid  = valid_r;
  assign f.pop_data   = mem[rp_r];
  assign f.level      = cnt_r;

  // ==========================================================================
  // Count and flags
  // ==========================================================================
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + LW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - LW'(1);
    end
  end

  // Flags registered from next count so both stay honest cycle by cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r   <= '0;
      ready_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      ready_r <= (cnt_nxt != LW'(DEPTH));
      valid_r <= (cnt_nxt != '0);
    end
  end

  // ==========================================================================
  // Pointers and storage
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      end
    end
  end

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= f.push_data;
    end
  end
endmodule
`default_nettype wire

// file: src/sync_pkg.sv
// Package: register map, field positions, widths and helpers for the sync and symbol-rate block
package sync_pkg;

  // ==========================================================================
  // Clock and rate constants
  // ==========================================================================
  localparam int unsigned CLK_HZ     = 10_000_000;  // Local clock, 100 ns period
  localparam int unsigned FCK_MAX_HZ = 70_000_000;  // Fastest device clock allowed

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int ADDR_W   = 8;   // Avalon byte address width
  localparam int DATA_W   = 32;  // Avalon data width
  localparam int SAMP_W   = 16;  // One I or Q word
  localparam int SYM_W    = 32;  // One I/Q pair
  localparam int N_W      = 16;  // Interpolation ratio width
  localparam int PAIR_W   = 18;  // Width holding 4N
  localparam int PERIOD_W = 24;  // Sync counter width
  localparam int COEF_W   = 16;  // Filter coefficient width
  localparam int CIDX_W   = 5;   // Stored coefficient index width
  localparam int TAP_W    = 6;   // Full impulse-response tap index width
  localparam int NUM_COEF = 32;  // Stored coefficients
  localparam int FIFO_DEPTH = 8; // Symbol buffer depth
  localparam int FIFO_LW    = 4; // Buffer level width

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h00;  // Control
  localparam logic [ADDR_W-1:0] INTERP_OFS   = 8'h04;  // Interpolation ratio N
  localparam logic [ADDR_W-1:0] PERIOD_OFS   = 8'h08;  // Sync counter period
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h0C;  // Status
  localparam logic [ADDR_W-1:0] COEF_OFS     = 8'h10;  // Coefficient write port
  localparam logic [ADDR_W-1:0] TAP_OFS      = 8'h14;  // Tap select / readback
  localparam logic [ADDR_W-1:0] SYNCCNT_OFS  = 8'h18;  // Live sync counter

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRL_MODE2X_BIT = 0;  // 1: two pairs per symbol
  localparam int CTRL_TCSEL_BIT  = 1;  // 1: sync out is terminal count
  localparam int CTRL_PULSE_BIT  = 2;  // Rising edge fires one-shot
  localparam int CTRL_RUN_BIT    = 3;  // Run symbol pacing
  localparam int CTRL_W          = 4;
  localparam int ST_UNDERRUN_BIT = 0;  // Sticky, write one to clear
  localparam int ST_PHASE_BIT    = 1;  // Second pair of a 2X symbol
  localparam int ST_LEVEL_LSB    = 8;  // Buffer level field
  localparam int COEF_IDX_LSB    = 16; // Coefficient index field

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [CTRL_W-1:0]   CTRL_RST   = 4'h0;
  localparam logic [N_W-1:0]      INTERP_RST = 16'h0008;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 24'h000040;
  localparam logic [TAP_W-1:0]    TAP_LAST   = 6'h3E;   // Index 62
  localparam logic [TAP_W-1:0]    COEF_LAST  = 6'h1F;   // Index 31, filter centre

  // ==========================================================================
  // Types and helpers
  // ==========================================================================
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,   // Waitrequest high, waiting for request
    BUS_ACK  = 2'b10    // Waitrequest low, request completes
  } bus_state_t;

  // Folds a tap index 0..62 onto the stored half 0..31
  function automatic logic [CIDX_W-1:0] mirror_tap(input logic [TAP_W-1:0] k);
    logic [TAP_W-1:0] m;
    m = (k > COEF_LAST) ? (TAP_LAST - k) : k;
    return m[CIDX_W-1:0];
  endfunction

  // Reload value for a down-counter of length len (len of zero acts as one)
  function automatic logic [PERIOD_W-1:0] reload_of(input logic [PERIOD_W-1:0] len);
    return (len == '0) ? '0 : len - 24'h000001;
  endfunction

endpackage

// file: src/sync_rate_top.sv
// Top: multi-device sync generator, symbol pacing and register slave
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sync_rate_top
  import sync_pkg::*;
(
  input  wire logic              clk,          // Clock, 10 MHz
  input  wire logic              reset,        // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] address,      // Avalon byte address
  input  wire logic              read,         // Avalon read
  input  wire logic              write,        // Avalon write
  input  wire logic [DATA_W-1:0] writedata,    // Avalon write data
  output logic      [DATA_W-1:0] readdata,     // Avalon read data
  output logic                   waitrequest,  // Avalon wait
  input  wire logic              sym_valid,    // Source offers an I/Q pair
  input  wire logic [SAMP_W-1:0] sym_i,        // In-phase word
  input  wire logic [SAMP_W-1:0] sym_q,        // Quadrature word
  output logic                   sym_ready,    // Buffer has room
  input  wire logic              sync_in,      // Shared sync strobe pin
  output logic                   sync_out,     // Sync output pin
  output logic                   req_out,      // Pair request pulse
  output logic      [SAMP_W-1:0] out_i,        // Output in-phase sample
  output logic      [SAMP_W-1:0] out_q,        // Output quadrature sample
  output logic                   out_valid     // Output sample valid
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  bus_state_t            bus_r;          // Bus handshake state
  logic [DATA_W-1:0]     rdata_r;        // Registered read data
  logic [CTRL_W-1:0]     ctrl_r;         // Control bits
  logic [N_W-1:0]        interp_r;       // Interpolation ratio N
  logic [PERIOD_W-1:0]   period_r;       // Sync counter period
  logic [TAP_W-1:0]      tap_r;          // Tap selected for readback
  logic [COEF_W-1:0]     coef [NUM_COEF]; // Stored half impulse response
  logic                  underrun_r;     // Sticky: pair due, buffer empty
  logic                  phase_r;        // Second pair of 2X symbol
  logic                  sync_meta_r;    // Synchroniser first stage
  logic                  sync_s_r;       // Synchroniser second stage
  logic                  sync_prev_r;    // Delayed copy for edge detect
  logic                  sync_evt;       // Rising edge of shared strobe
  logic [PAIR_W-1:0]     pair_cnt_r;     // Counts 4N clocks per pair
  logic                  pair_tick;      // Pair slot ends
  logic [PERIOD_W-1:0]   sync_cnt_r;     // Sync down-counter
  logic                  tc;             // Terminal count
  logic                  pulse_prev_r;   // Previous one-shot control bit
  logic                  pulse_fire;     // One-shot edge
  logic                  sync_out_r;     // Registered sync output
  logic                  req_r;          // Registered request pulse
  logic [SYM_W-1:0]      hold_r;         // Pair held for the output
  logic [SAMP_W-1:0]     out_i_r;        // Output sample I
  logic [SAMP_W-1:0]     out_q_r;        // Output sample Q
  logic                  out_valid_r;    // Output valid
  logic                  wr_go;          // Write completes this edge
  logic                  run;            // Pacing enabled
  logic [PAIR_W-1:0]     pair_reload;    // 4N minus one

  fifo_if #(.W(SYM_W), .LW(FIFO_LW)) fq ();  // Buffer connection

  assign run         = ctrl_r[CTRL_RUN_BIT];
  assign wr_go       = write && (bus_r == BUS_ACK);
  assign pair_reload = {interp_r, 2'b00} - PAIR_W'(1);
  assign sync_evt    = sync_s_r & ~sync_prev_r;
  assign pair_tick   = run && (pair_cnt_r == '0);
  assign tc          = (sync_cnt_r == '0);
  assign pulse_fire  = ctrl_r[CTRL_PULSE_BIT] & ~pulse_prev_r;

  // ==========================================================================
  // Symbol buffer
  // ==========================================================================
  assign fq.push_valid = sym_valid;
  assign fq.push_data  = {sym_i, sym_q};
  assign fq.pop_ready  = pair_tick;

  sym_fifo #(.WIDTH(SYM_W), .DEPTH(FIFO_DEPTH), .LW(FIFO_LW)) u_fifo (
    .clk   (clk),
    .reset (reset),
    .f     (fq.store)
  );

  // ==========================================================================
  // Avalon handshake: one wait cycle, then completion
  // ==========================================================================
  // Waitrequest is high in idle and drops for exactly one cycle per request
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_r <= BUS_IDLE;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (read || write) begin
            bus_r <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_r <= BUS_IDLE;   // Request finishes at this edge
        end
        default: begin
          bus_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // Read data captured as waitrequest falls, so it stands at the sampling edge
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else if (bus_r == BUS_IDLE && read) begin
      case (address)
        CTRL_OFS:    rdata_r <= DATA_W'(ctrl_r);
        INTERP_OFS:  rdata_r <= DATA_W'(interp_r);
        PERIOD_OFS:  rdata_r <= DATA_W'(period_r);
        STATUS_OFS: begin
          rdata_r <= '0;
          rdata_r[ST_UNDERRUN_BIT] <= underrun_r;
          rdata_r[ST_PHASE_BIT]    <= phase_r;
          rdata_r[ST_LEVEL_LSB +: FIFO_LW] <= fq.level;
        end
        // Readback folds the second half onto the stored first half
        TAP_OFS:     rdata_r <= {10'h000, tap_r, coef[mirror_tap(tap_r)]};
        SYNCCNT_OFS: rdata_r <= DATA_W'(sync_cnt_r);
        default:     rdata_r <= '0;   // Unmapped reads return zero
      endcase
    end
  end

  // ==========================================================================
  // Control registers
  // ==========================================================================
  // Writes land at the edge where waitrequest is seen low; unmapped ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r   <= CTRL_RST;
      interp_r <= INTERP_RST;
      period_r <= PERIOD_RST;
      tap_r    <= '0;
    end else if (wr_go) begin
      case (address)
        CTRL_OFS:   ctrl_r   <= writedata[CTRL_W-1:0];
        INTERP_OFS: interp_r <= writedata[N_W-1:0];
        // Software keeps this a multiple of 8N when terminal count is shared
        PERIOD_OFS: period_r <= writedata[PERIOD_W-1:0];
        TAP_OFS:    tap_r    <= writedata[TAP_W-1:0];
        default:    tap_r    <= tap_r;
      endcase
    end
  end

  // Coefficient store: only the first half of the response is kept
  always_ff @(posedge clk) begin
    if (wr_go && address == COEF_OFS) begin
      coef[writedata[COEF_IDX_LSB +: CIDX_W]] <= writedata[COEF_W-1:0];
    end
  end

  // ==========================================================================
  // Sync input synchroniser
  // ==========================================================================
  // The strobe comes from a pin, so two stages before any edge logic
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_meta_r <= 1'b0;
      sync_s_r    <= 1'b0;
      sync_prev_r <= 1'b0;
    end else begin
      sync_meta_r <= sync_in;
      sync_s_r    <= sync_meta_r;
      sync_prev_r <= sync_s_r;
    end
  end

  // ==========================================================================
  // Sync counter and sync output
  // ==========================================================================
  // Every device seeing the same strobe reloads on the same clock
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_cnt_r <= PERIOD_RST - PERIOD_W'(1);  // Counts period-1..0 from the start
    end else if (sync_evt || tc) begin
      sync_cnt_r <= reload_of(period_r);
    end else begin
      sync_cnt_r <= sync_cnt_r - PERIOD_W'(1);
    end
  end

  // One-shot fires on the rising edge of the control bit
  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_prev_r <= 1'b0;
    end else begin
      pulse_prev_r <= ctrl_r[CTRL_PULSE_BIT];
    end
  end

  // Output selects between the two sync sources
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_out_r <= 1'b0;
    end else if (ctrl_r[CTRL_TCSEL_BIT]) begin
      sync_out_r <= tc;
    end else begin
      sync_out_r <= pulse_fire;
    end
  end

  // ==========================================================================
  // Pair pacing: one pair each 4N clocks in both modes
  // ==========================================================================
  // 1X symbol = 4N clocks, 2X symbol = 8N clocks holding two pairs
  always_ff @(posedge clk) begin
    if (reset) begin
      pair_cnt_r <= '0;
      phase_r    <= 1'b0;
    end else if (sync_evt || !run) begin
      pair_cnt_r <= pair_reload;
      phase_r    <= 1'b0;
    end else if (pair_tick) begin
      pair_cnt_r <= pair_reload;
      phase_r    <= ctrl_r[CTRL_MODE2X_BIT] & ~phase_r;
    end else begin
      pair_cnt_r <= pair_cnt_r - PAIR_W'(1);
    end
  end

  // Request pulse lets the source pace its input
  always_ff @(posedge clk) begin
    if (reset) begin
      req_r <= 1'b0;
    end else begin
      req_r <= pair_tick;
    end
  end

  // Take the next pair; an empty buffer holds zero and flags underrun
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_r <= '0;
    end else if (pair_tick) begin
      hold_r <= fq.pop_valid ? fq.pop_data : '0;
    end
  end

  // Sticky underrun: a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      underrun_r <= 1'b0;
    end else if (pair_tick && !fq.pop_valid) begin
      underrun_r <= 1'b1;
    end else if (wr_go && address == STATUS_OFS && writedata[ST_UNDERRUN_BIT]) begin
      underrun_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Output samples, one per clock
  // ==========================================================================
  // Rate limit is the clock itself; 10 MHz sits below the 70 MHz ceiling
  always_ff @(posedge clk) begin
    if (reset) begin
      out_i_r     <= '0;
      out_q_r     <= '0;
      out_valid_r <= 1'b0;
    end else begin
      out_i_r     <= hold_r[SYM_W-1:SAMP_W];
      out_q_r     <= hold_r[SAMP_W-1:0];
      out_valid_r <= run;
    end
  end

  assign readdata    = rdata_r;
  assign waitrequest = (bus_r != BUS_ACK);
  assign sym_ready   = fq.push_ready;
  assign sync_out    = sync_out_r;
  assign req_out     = req_r;
  assign out_i       = out_i_r;
  assign out_q       = out_q_r;
  assign out_valid   = out_valid_r;

endmodule
`default_nettype wire

// file: tb/sym_source.sv
// Partner: upstream symbol source offering I/Q pairs, zero-stuffed on request
`timescale 1ns/1ps
`default_nettype none
module sym_source (
  input  wire logic        clk,        // Clock
  input  wire logic        en,         // Offer pairs
  input  wire logic        zero_fill,  // Interleave zero pairs
  input  wire logic        sym_ready,  // Buffer room
  output logic             sym_valid,  // Pair offered
  output logic      [15:0] sym_i,      // In-phase word
  output logic      [15:0] sym_q       // Quadrature word
);
  logic [7:0] cnt_r;  // Pairs taken so far
  logic [7:0] k;      // Index of pair to offer

  initial begin
    sym_valid = 1'b0;
    sym_i = 16'hA5A5;
    sym_q = 16'h5A5A;
    cnt_r = 8'h00;
  end

  // ====
  // Data is a pure function of the index, so a refused pair is held as is
  always @(posedge clk) begin
    k = cnt_r + {7'h00, sym_valid && sym_ready};
    cnt_r <= k;
    sym_valid <= en;
    if (!en) begin
      // Released lines scramble so a stale word never looks valid
      sym_i <= ~sym_i;
      sym_q <= ~sym_q;
    end else if (zero_fill && k[0]) begin
      sym_i <= 16'h0000;
      sym_q <= 16'h0000;
    end else begin
      sym_i <= {8'h11, k};
      sym_q <= {8'h22, k};
    end
  end
endmodule
`default_nettype wire

// file: tb/sync_rate_chk.sv
// Checker: bus handshake, pacing and sync pulse properties at the top ports
`timescale 1ns/1ps
`default_nettype none
module sync_rate_chk
  import sync_pkg::*;
(
  input wire logic              clk,          // Clock
  input wire logic              reset,        // Sync reset
  input wire logic [ADDR_W-1:0] address,      // Bus address
  input wire logic              read,         // Bus read
  input wire logic              write,        // Bus write
  input wire logic [DATA_W-1:0] writedata,    // Bus write data
  input wire logic [DATA_W-1:0] readdata,     // Bus read data
  input wire logic              waitrequest,  // Bus wait
  input wire logic              sym_valid,    // Pair offered
  input wire logic [SAMP_W-1:0] sym_i,        // In-phase in
  input wire logic [SAMP_W-1:0] sym_q,        // Quadrature in
  input wire logic              sym_ready,    // Buffer room
  input wire logic              sync_in,      // Strobe pin
  input wire logic              sync_out,     // Sync output
  input wire logic              req_out,      // Pair request
  input wire logic [SAMP_W-1:0] out_i,        // Sample I
  input wire logic [SAMP_W-1:0] out_q,        // Sample Q
  input wire logic              out_valid     // Sample valid
);
  // ====
  // One clock domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_wait_once: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in one cycle");
  // Read data may only move at the edge that takes a read
  a_rdata_hold: assert property ($changed(readdata) |-> $past(read) && $past(waitrequest))
    else $error("read data changed without a read");
  // Slots are 4N apart and N is at least one
  a_req_spacing: assert property (req_out |=> !req_out [*3])
    else $error("pair requests too close");
  // The sample only moves the clock after a request
  a_out_hold: assert property (!$past(req_out) |-> $stable(out_i) && $stable(out_q))
    else $error("output sample moved without a request");
  a_sync_single: assert property (sync_out |=> !sync_out)
    else $error("sync output longer than one cycle");
endmodule

bind sync_rate_top sync_rate_chk chk (.clk(clk), .reset(reset), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .sym_valid(sym_valid), .sym_i(sym_i), .sym_q(sym_q),
  .sym_ready(sym_ready), .sync_in(sync_in), .sync_out(sync_out), .req_out(req_out),
  .out_i(out_i), .out_q(out_q), .out_valid(out_valid));
`default_nettype wire

// file: tb/tb_top.sv
// Testbench: registers, coefficients, pacing, buffer and sync scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sync_pkg::*;
;
  logic clk, reset, read, write, sym_valid, sym_ready, waitrequest;  // Bus and stream
  logic sync_in, sync_out, req_out, out_valid, src_en, src_zero;    // Pins, source control
  logic req_d = 1'b0;                                               // Request one clock ago
  logic [ADDR_W-1:0] address;                                       // Bus address
  logic [DATA_W-1:0] writedata, readdata, q;                        // Bus data
  logic [SAMP_W-1:0] sym_i, sym_q, out_i, out_q;                    // Pairs
  logic [31:0] exp_q[$];                                            // Pairs taken, oldest first
  int mismatches = 0, checked = 0, sync_n = 0, n = 0;               // Tallies

  sync_rate_top dut (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sym_valid(sym_valid), .sym_i(sym_i), .sym_q(sym_q), .sym_ready(sym_ready),
    .sync_in(sync_in), .sync_out(sync_out), .req_out(req_out), .out_i(out_i), .out_q(out_q),
    .out_valid(out_valid));
  sym_source src (.clk(clk), .en(src_en), .zero_fill(src_zero), .sym_ready(sym_ready),
    .sym_valid(sym_valid), .sym_i(sym_i), .sym_q(sym_q));

  // ====
  // 10 MHz, so clock over 4N stays far above the floor
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic guard(input int k);
    if (k >= 300) begin
      mismatches++;
      stop_test();
    end
  endtask

  // Holds the request until waitrequest is sampled low, then takes data
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 300);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    guard(k);
    @(posedge clk);
  endtask

  // Counts edges until request, sync pulse or a full buffer is seen
  task automatic wait_on(input int sel);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel == 0 ? req_out : sel == 1 ? sync_out : !sym_ready) !== 1'b1 && n < 300);
    guard(n);
  endtask

  // Monitor: every sample must be the oldest pair taken, zero after underrun
  always @(posedge clk) begin
    if (sym_valid && sym_ready) exp_q.push_back({sym_i, sym_q});
    if (sync_out) sync_n++;
    if (req_d) check("out pair", {out_i, out_q}, exp_q.size() > 0 ? exp_q.pop_front() : 0);
    req_d <= req_out && !reset;
  end

  task automatic t_regs();
    bus(0, CTRL_OFS, 0);
    check("ctrl", q, 32'h0);
    bus(0, INTERP_OFS, 0);
    check("interp", q, 32'h8);
    bus(0, PERIOD_OFS, 0);
    check("period", q, 32'h40);
    bus(0, 8'h1C, 0);
    check("unmapped", q, 32'h0);
  endtask

  task automatic t_coef();
    for (int i = 0; i < 32; i++) begin
      bus(1, COEF_OFS, {11'h0, 5'(i), 16'h1000 + 16'(i)});
    end
    for (int k = 0; k < 63; k++) begin
      bus(1, TAP_OFS, 32'(k));
      bus(0, TAP_OFS, 0);
      check("tap", q, {10'h0, 6'(k), 16'h1000 + 16'(k <= 31 ? k : 62 - k)});
    end
  endtask

  // Fill until refused, then drain with the source stalled into underrun
  task automatic t_fill();
    bus(1, INTERP_OFS, 32'h2);
    src_en <= 1'b1;
    wait_on(2);
    src_en <= 1'b0;
    bus(0, STATUS_OFS, 0);
    check("level", {28'h0, q[11:8]}, 32'h8);
    bus(1, CTRL_OFS, 32'h8);
    @(posedge clk);
    check("valid", {31'h0, out_valid}, 32'h1);
    wait_on(0);
    wait_on(0);
    check("slot 1x", n, 32'h8);
    repeat (80) @(posedge clk);
    bus(1, CTRL_OFS, 0);
    bus(0, STATUS_OFS, 0);
    check("underrun", {31'h0, q[0]}, 32'h1);
    bus(1, STATUS_OFS, 32'h1);
    bus(0, STATUS_OFS, 0);
    check("cleared", {31'h0, q[0]}, 32'h0);
  endtask

  task automatic t_2x();
    src_zero <= 1'b1;
    src_en <= 1'b1;
    wait_on(2);
    bus(1, CTRL_OFS, 32'h9);
    wait_on(0);
    wait_on(0);
    check("slot 2x", n, 32'h8);
    wait_on(0);
    bus(0, STATUS_OFS, 0);
    check("phase", {31'h0, q[1]}, 32'h1);
    repeat (120) @(posedge clk);
    src_en <= 1'b0;
    bus(1, CTRL_OFS, 0);
  endtask

  task automatic t_sync();
    int s0;
    bus(1, PERIOD_OFS, 32'h20);
    bus(1, CTRL_OFS, 32'h2);
    wait_on(1);
    wait_on(1);
    check("tc period", n, 32'h20);
    repeat (10) @(posedge clk);
    sync_in <= 1'b1;
    wait_on(1);
    sync_in <= 1'b0;
    check("realign", {31'h0, n >= 32 && n <= 38}, 32'h1);
    bus(1, CTRL_OFS, 0);
    s0 = sync_n;
    bus(1, CTRL_OFS, 32'h4);
    bus(1, CTRL_OFS, 0);
    repeat (40) @(posedge clk);
    check("one-shot", sync_n - s0, 32'h1);
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    {read, write, sync_in, src_en, src_zero} = '0;
    address = '0;
    writedata = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_coef();
    t_fill();
    t_2x();
    t_sync();
    stop_test();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
